/* rtl/remote_setup_command_decoder.sv */
// command decoder for the remote setup group, reached over apb
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Behaviour
// RULE_01: aux input query returns channel 1/2 reading
// RULE_02: aux input set form is rejected
// RULE_03: aux output channel 1/2, limit +-10.500 V
// RULE_04: responses to serial (0) or gpib (1)
// RULE_05: host selects response port before queries
// RULE_06: override off/on, defaults on, panel live
// RULE_07: any command but local goes remote/lockout
// RULE_08: override off, remote: only Local key
// RULE_09: lockout disables panel until override or local
// RULE_10: Local key in remote returns to local
// RULE_11: key click on/off, readable
// RULE_12: alarm on/off, readable
// RULE_13: save setup into buffer 1 to 9
// RULE_14: recall keeps interface parameters unchanged
// RULE_15: recall of unsaved buffer raises error
// RULE_16: knob steps signed -32767 to 32767
// RULE_17: one key press per keypress command
// RULE_18: plain keycodes through sparse map 0-61
// RULE_19: shifted keycodes are plain code plus 64
// RULE_20: bad keycode or range gives error, no change
module remote_setup_command_decoder
	import remote_setup_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from the instrument
	input wire logic [15:0] aux_in1_pin,
	input wire logic [15:0] aux_in2_pin,
	input wire logic lockout_pin,
	input wire logic panel_strobe_pin,
	input wire logic [6:0] panel_code_pin,
	// controls toward the instrument
	output setup_t setup,
	output logic response_port,
	output logic panel_override_mode,
	output logic remote_led,
	output logic panel_enable,
	output key_event_t key_event,
	output knob_event_t knob_event
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// keycode lookup, plain and shifted
	function automatic logic key_known(input logic [6:0] code);
		key_known = code[6] ? KEY_MAP_SHIFT[code[5:0]] : KEY_MAP_PLAIN[code[5:0]];
	endfunction

	// channel index 1 or 2
	function automatic logic chan_ok(input logic [3:0] idx);
		chan_ok = (idx == 4'h1) || (idx == 4'h2);
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [15:0] aux1_meta, aux1_sync, aux2_meta, aux2_sync;
	logic lock_meta, lock_sync, strb_meta, strb_sync, strb_last;
	logic [6:0] code_meta, code_sync;

	// aux pin buses, named before the synchronisers read them
	wire [15:0] aux1_pin_w = aux_in1_pin;
	wire [15:0] aux2_pin_w = aux_in2_pin;

	// two flops on every pin before use
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			aux1_meta <= 16'h0000;
			aux1_sync <= 16'h0000;
			aux2_meta <= 16'h0000;
			aux2_sync <= 16'h0000;
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
			strb_meta <= 1'b0;
			strb_sync <= 1'b0;
			strb_last <= 1'b0;
			code_meta <= 7'h00;
			code_sync <= 7'h00;
		end
		else
		begin
			aux1_meta <= aux1_pin_w;
			aux1_sync <= aux1_meta;
			aux2_meta <= aux2_pin_w;
			aux2_sync <= aux2_meta;
			lock_meta <= lockout_pin;
			lock_sync <= lock_meta;
			strb_meta <= panel_strobe_pin;
			strb_sync <= strb_meta;
			strb_last <= strb_sync;
			code_meta <= panel_code_pin;
			code_sync <= code_meta;
		end
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic [31:0] arg;
	logic [31:0] resp;
	logic err;
	panel_state_t state;
	logic [SETUP_COUNT-1:0] saved;
	setup_t store [SETUP_COUNT];

	wire access = psel && penable;
	wire wr = access && pwrite;
	wire hit_cmd = paddr == ADDR_CMD;
	wire hit_arg = paddr == ADDR_ARG;
	wire hit_resp = paddr == ADDR_RESP;
	wire hit_stat = paddr == ADDR_STATUS;
	wire hit_aux = paddr == ADDR_AUXOUT;
	wire mapped = hit_cmd || hit_arg || hit_resp || hit_stat || hit_aux;
	wire exec = wr && hit_cmd;
	wire clr_err = wr && hit_stat && pwdata[STATUS_ERR_BIT];

	// zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// read word chosen from the address
	wire [31:0] status_word = {23'h0, panel_enable, remote_led, state, setup.alarm,
		setup.click, panel_override_mode, response_port, err};
	wire [31:0] read_word = hit_arg ? arg : hit_resp ? resp : hit_stat ? status_word :
		hit_aux ? {setup.aux_out2, setup.aux_out1} : 32'h0000_0000;

	// read data taken at the end of the setup phase, so it stands from a flop through the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= read_word;
	end

	// ----------------------------------------
	// command fields and checks
	// ----------------------------------------
	wire [3:0] op_raw = pwdata[3:0];
	wire [3:0] idx = pwdata[7:4];
	wire query = pwdata[CMD_QUERY_BIT];
	wire signed [31:0] sarg = arg;
	wire bit_arg_ok = arg[31:1] == 31'h0;
	wire aux_range_ok = (sarg <= AUX_OUT_MAX_MV) && (sarg >= -AUX_OUT_MAX_MV);
	wire knob_ok = (sarg <= KNOB_MAX) && (sarg >= -KNOB_MAX);
	wire buf_ok = (idx >= SETUP_FIRST) && (idx <= SETUP_LAST);
	wire [3:0] buf_sel = idx - SETUP_FIRST;
	wire key_ok = (arg[31:7] == 25'h0) && key_known(arg[6:0]);
	wire buf_saved = buf_ok && saved[buf_sel];
	wire signed [15:0] aux_in_sel = (idx == 4'h1) ? aux1_sync : aux2_sync;

	// error and acceptance for each command
	logic cmd_err;
	always_comb
	begin
		cmd_err = 1'b0;
		case (op_raw)
			OP_AUX_INPUT_QUERY: cmd_err = !query || !chan_ok(idx); // [RULE_01] [RULE_02]
			OP_AUX_OUTPUT_SET: cmd_err = !chan_ok(idx) || (!query && !aux_range_ok); // [RULE_03] [RULE_20]
			OP_RESPONSE_PORT_SELECT, OP_PANEL_OVERRIDE_MODE,
			OP_KEY_CLICK_SWITCH, OP_ALARM_SWITCH: cmd_err = !query && !bit_arg_ok; // [RULE_20]
			OP_SETUP_SAVE: cmd_err = query || !buf_ok; // [RULE_13]
			OP_SETUP_RECALL: cmd_err = query || !buf_saved; // [RULE_15]
			OP_KNOB_STEPS: cmd_err = query || !knob_ok; // [RULE_16] [RULE_20]
			OP_KEYPRESS_EMULATION: cmd_err = query || !key_ok; // [RULE_18] [RULE_19] [RULE_20]
			OP_RETURN_TO_LOCAL: cmd_err = query;
			default: cmd_err = 1'b1;
		endcase
	end

	wire go = exec && !cmd_err;
	wire set_go = go && !query;
	wire is_op_aux = op_raw == OP_AUX_OUTPUT_SET;

	// query answers
	logic [31:0] next_resp;
	always_comb
	begin
		next_resp = resp;
		if (go && query)
		begin
			case (op_raw)
				OP_AUX_INPUT_QUERY: next_resp = {{16{aux_in_sel[15]}}, aux_in_sel}; // [RULE_01]
				OP_AUX_OUTPUT_SET: next_resp = (idx == 4'h1) ? {{16{setup.aux_out1[15]}}, setup.aux_out1}
					: {{16{setup.aux_out2[15]}}, setup.aux_out2};
				OP_RESPONSE_PORT_SELECT: next_resp = {31'h0, response_port};
				OP_PANEL_OVERRIDE_MODE: next_resp = {31'h0, panel_override_mode};
				OP_KEY_CLICK_SWITCH: next_resp = {31'h0, setup.click}; // [RULE_11]
				OP_ALARM_SWITCH: next_resp = {31'h0, setup.alarm}; // [RULE_12]
				default: next_resp = resp;
			endcase
		end
	end

	// ----------------------------------------
	// setup next value
	// ----------------------------------------
	setup_t next_setup;
	always_comb
	begin
		next_setup = setup;
		if (set_go && op_raw == OP_SETUP_RECALL)
			next_setup = store[buf_sel[3:0]]; // [RULE_14]
		if (set_go && is_op_aux && idx == 4'h1)
			next_setup.aux_out1 = arg[15:0]; // [RULE_03]
		if (set_go && is_op_aux && idx == 4'h2)
			next_setup.aux_out2 = arg[15:0]; // [RULE_03]
		if (set_go && op_raw == OP_KEY_CLICK_SWITCH)
			next_setup.click = arg[0]; // [RULE_11]
		if (set_go && op_raw == OP_ALARM_SWITCH)
			next_setup.alarm = arg[0]; // [RULE_12]
	end

	// ----------------------------------------
	// front panel state
	// ----------------------------------------
	wire panel_press = strb_sync && !strb_last;
	wire panel_is_local = code_sync == KEY_LOCAL;
	wire local_cmd = exec && op_raw == OP_RETURN_TO_LOCAL;
	// override keeps everything live, lockout kills all, remote keeps Local only
	wire key_accept = panel_press && (panel_override_mode || state == ST_LOCAL
		|| (state == ST_REMOTE && panel_is_local)); // [RULE_06] [RULE_08] [RULE_09]

	panel_state_t next_state;
	always_comb
	begin
		next_state = state;
		case (state)
			ST_LOCAL, ST_REMOTE, ST_LOCKOUT:
			begin
				if (key_accept && panel_is_local && state == ST_REMOTE)
					next_state = ST_LOCAL; // [RULE_10]
				if (exec)
					next_state = lock_sync ? ST_LOCKOUT : ST_REMOTE; // [RULE_07]
				if (local_cmd)
					next_state = ST_LOCAL; // [RULE_09]
			end
			default: next_state = ST_LOCAL;
		endcase
	end

	assign remote_led = state != ST_LOCAL; // [RULE_07]
	assign panel_enable = panel_override_mode || state == ST_LOCAL; // [RULE_09]

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// argument and answer words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			arg <= 32'h0000_0000;
			resp <= 32'h0000_0000;
			err <= 1'b0;
		end
		else
		begin
			if (wr && hit_arg)
				arg <= pwdata;
			resp <= next_resp;
			err <= (exec && cmd_err) || (err && !clr_err); // [RULE_20]
		end
	end

	// settings, interface parameters and panel state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			setup <= '{aux_out1: 16'h0000, aux_out2: 16'h0000, click: RST_CLICK, alarm: RST_ALARM};
			response_port <= RST_PORT;
			panel_override_mode <= RST_OVERRIDE; // [RULE_06]
			state <= ST_LOCAL;
		end
		else
		begin
			setup <= next_setup;
			if (set_go && op_raw == OP_RESPONSE_PORT_SELECT)
				response_port <= arg[0]; // [RULE_04]
			if (set_go && op_raw == OP_PANEL_OVERRIDE_MODE)
				panel_override_mode <= arg[0]; // [RULE_06]
			state <= next_state;
		end
	end

	// setup buffers, contents kept without reset like a backed store
	always_ff @(posedge pclk)
	begin
		if (set_go && op_raw == OP_SETUP_SAVE)
			store[buf_sel[3:0]] <= setup; // [RULE_13]
	end

	// buffer valid flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			saved <= '0;
		else if (set_go && op_raw == OP_SETUP_SAVE)
			saved[buf_sel[3:0]] <= 1'b1; // [RULE_13]
	end

	// ----------------------------------------
	// key and knob events
	// ----------------------------------------
	wire remote_key = set_go && op_raw == OP_KEYPRESS_EMULATION;

	// one press per keypress command or accepted panel press, a panel press in the same cycle as a keypress command is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_event <= '0;
			knob_event <= '0;
		end
		else
		begin
			key_event.pulse <= remote_key || key_accept; // [RULE_17]
			key_event.from_remote <= remote_key;
			key_event.code <= remote_key ? arg[6:0] : code_sync; // [RULE_18] [RULE_19]
			knob_event.pulse <= set_go && op_raw == OP_KNOB_STEPS; // [RULE_16]
			knob_event.steps <= arg[15:0];
		end
	end

endmodule

/* rtl/remote_setup_pkg.sv */
// package with register map, command codes and carrier types for the setup command decoder
package remote_setup_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_ARG = 8'h04;
	localparam logic [7:0] ADDR_RESP = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_AUXOUT = 8'h10;

	// ----------------------------------------
	// field positions and limits
	// ----------------------------------------
	localparam int CMD_QUERY_BIT = 8;
	localparam int STATUS_ERR_BIT = 0;
	localparam logic signed [31:0] AUX_OUT_MAX_MV = 32'sd10500;
	localparam logic signed [31:0] KNOB_MAX = 32'sd32767;
	localparam logic [3:0] SETUP_FIRST = 4'h1;
	localparam logic [3:0] SETUP_LAST = 4'h9;
	localparam int SETUP_COUNT = 9;
	localparam logic [6:0] KEY_LOCAL = 7'h29;
	localparam logic [6:0] KEY_SHIFT_OFFSET = 7'h40;
	localparam logic [63:0] KEY_MAP_PLAIN = 64'h3A0F_3F3F_3D3F_373F;
	localparam logic [63:0] KEY_MAP_SHIFT = 64'h020A_193C_0000_1411;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic RST_OVERRIDE = 1'b1;
	localparam logic RST_CLICK = 1'b1;
	localparam logic RST_ALARM = 1'b1;
	localparam logic RST_PORT = 1'b0;

	// ----------------------------------------
	// command codes, states and carriers
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_AUX_INPUT_QUERY, OP_AUX_OUTPUT_SET, OP_RESPONSE_PORT_SELECT,
		OP_PANEL_OVERRIDE_MODE, OP_KEY_CLICK_SWITCH, OP_ALARM_SWITCH,
		OP_SETUP_SAVE, OP_SETUP_RECALL, OP_KNOB_STEPS, OP_KEYPRESS_EMULATION,
		OP_RETURN_TO_LOCAL
	} opcode_t;

	typedef enum logic [1:0] {
		ST_LOCAL, ST_REMOTE, ST_LOCKOUT
	} panel_state_t;

	typedef struct packed {
		logic signed [15:0] aux_out1;
		logic signed [15:0] aux_out2;
		logic click;
		logic alarm;
	} setup_t;

	typedef struct packed {
		logic pulse;
		logic from_remote;
		logic [6:0] code;
	} key_event_t;

	typedef struct packed {
		logic pulse;
		logic signed [15:0] steps;
	} knob_event_t;

endpackage

/* verif/remote_setup_chk.sv */
// port checker for the setup command decoder
`timescale 1ns/1ps
module remote_setup_chk
	import remote_setup_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// controls
	input wire setup_t setup,
	input wire logic response_port,
	input wire logic panel_override_mode,
	input wire logic remote_led,
	input wire logic panel_enable,
	input wire key_event_t key_event,
	input wire knob_event_t knob_event
);
	logic [31:0] arg;
	// command write decode and argument range checks
	wire logic wr_cmd = psel && penable && pwrite && paddr == ADDR_CMD;
	wire logic go = wr_cmd && !pwdata[CMD_QUERY_BIT];
	wire logic [3:0] op = pwdata[3:0];
	wire logic in_aux = $signed(arg) <= AUX_OUT_MAX_MV && $signed(arg) >= -AUX_OUT_MAX_MV;
	wire logic in_knob = $signed(arg) <= KNOB_MAX && $signed(arg) >= -KNOB_MAX;
	wire logic key_ok = arg < 32'h80 && (arg[6] ? KEY_MAP_SHIFT[arg[5:0]] : KEY_MAP_PLAIN[arg[5:0]]);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// copy of the argument word
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) arg <= 32'h0;
		else if (psel && penable && pwrite && paddr == ADDR_ARG) arg <= pwdata;
	led_after_cmd_a: assert property (wr_cmd |=> remote_led == ($past(op) != 4'hA))
		else $error("remote indicator wrong");
	panel_gate_a: assert property (panel_enable == (panel_override_mode || !remote_led))
		else $error("panel enable wrong");
	port_sel_a: assert property (go && op == 4'h2 && arg < 32'h2 |=> response_port == arg[0])
		else $error("response port wrong");
	override_set_a: assert property (go && op == 4'h3 && arg < 32'h2 |=> panel_override_mode == arg[0])
		else $error("override wrong");
	aux_set_a: assert property (go && op == 4'h1 && pwdata[7:4] == 4'h1 && in_aux |=> setup.aux_out1 == arg[15:0])
		else $error("aux output wrong");
	aux_refuse_a: assert property (go && op == 4'h1 && !in_aux |=> $stable(setup))
		else $error("aux output changed");
	knob_pulse_a: assert property (go && op == 4'h8 && in_knob |=>
		knob_event.pulse && knob_event.steps == arg[15:0] ##1 !knob_event.pulse)
		else $error("knob event wrong");
	key_pulse_a: assert property (go && op == 4'h9 && key_ok |=>
		key_event.pulse && key_event.from_remote && key_event.code == arg[6:0])
		else $error("key event wrong");
endmodule

/* verif/panel_model.sv */
// front panel model giving one key press per request
`timescale 1ns/1ps
module panel_model
(
	// clock and request
	input wire logic pclk,
	input wire logic press,
	input wire logic [6:0] code,
	// panel pins
	output logic strobe,
	output logic [6:0] key_code
);
	logic [2:0] left = 3'h0;
	logic [6:0] held = 7'h0;
	// strobe stands six cycles, code inverted while idle
	assign strobe = left != 3'h0;
	assign key_code = strobe ? held : ~held;
	always_ff @(posedge pclk)
	begin
		if (press) held <= code;
		left <= press ? 3'h6 : left - {2'h0, strobe};
	end
endmodule

/* verif/remote_setup_command_decoder_tb_top.sv */
// self-checking bench for the setup command decoder
`timescale 1ns/1ps
module remote_setup_command_decoder_tb_top;
	import remote_setup_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, response_port, panel_override_mode, remote_led;
	logic panel_enable, lockout_pin, strobe, press, port, ovr, click, alarm, err, ok;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] aux1, aux2;
	logic [6:0] pcode, kcode;
	logic [1:0] st;
	setup_t setup;
	key_event_t key_event;
	knob_event_t knob_event;
	logic [32:0] rq[$], kq[$], nq[$];
	int n_fail = 0, checks = 0, seed;
	remote_setup_command_decoder i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .aux_in1_pin(aux1), .aux_in2_pin(aux2), .lockout_pin, .panel_strobe_pin(strobe),
		.panel_code_pin(kcode), .setup, .response_port, .panel_override_mode, .remote_led, .panel_enable,
		.key_event, .knob_event);
	panel_model i_panel (.pclk, .press, .code(pcode), .strobe, .key_code(kcode));
	task automatic chk(input string n, ref logic [32:0] q[$], input logic [32:0] g);
		logic [32:0] e;
		e = q.size() ? q.pop_front() : 33'hX;
		checks++;
		if (e !== g)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rd(); chk($sformatf("reg %h", paddr), rq, {pslverr, prdata}); endtask
	task automatic chk_key(); chk("key", kq, {24'h0, key_event}); endtask
	task automatic chk_knob(); chk("knob", nq, {17'h0, knob_event.steps}); endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back({a > ADDR_AUXOUT, e});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic cmd(input logic [3:0] op, input logic [3:0] i, input logic q, input logic [31:0] v, input logic e);
		apb(1'b1, ADDR_ARG, v);
		apb(1'b1, ADDR_CMD, {23'h0, q, i, op});
		st = op == 4'hA ? 2'h0 : lockout_pin ? 2'h2 : 2'h1;
		err = err | e;
	endtask
	task automatic clr();
		apb(1'b1, ADDR_STATUS, 32'h1);
		err = 1'b0;
	endtask
	task automatic pr(input logic [6:0] c);
		press <= 1'b1;
		pcode <= c;
		@(posedge pclk) press <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask
	function automatic logic [31:0] stat();
		return {23'h0, ovr | st == 2'h0, st != 2'h0, st, alarm, click, ovr, port, err};
	endfunction
	task automatic test_done();
		n_fail += rq.size() + kq.size() + nq.size();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// result monitor takes the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite) chk_rd();
		if (key_event.pulse === 1'b1) chk_key();
		if (knob_event.pulse === 1'b1) chk_knob();
	end
	// watchdog
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		test_done();
	end
	// main sequence
	initial
	begin
		seed = 99013;
		{presetn, psel, penable, pwrite, press, lockout_pin, paddr, pwdata, pcode} = 53'h0;
		aux1 = 16'($random(seed));
		aux2 = 16'($random(seed));
		{port, ovr, click, alarm, err, st} = {RST_PORT, RST_OVERRIDE, RST_CLICK, RST_ALARM, 3'h0};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_STATUS, stat());
		rd(8'h14, 32'h0);
		$display("done: reset");
		for (int o = 2; o < 6; o++)
			for (int v = 0; v < 2; v++)
			begin
				cmd(o[3:0], 4'h0, 1'b0, v, 1'b0);
				case (o)
					2: port = v[0];
					3: ovr = v[0];
					4: click = v[0];
					default: alarm = v[0];
				endcase
				cmd(o[3:0], 4'h0, 1'b1, 32'h0, 1'b0);
				rd(ADDR_RESP, v);
				rd(ADDR_STATUS, stat());
			end
		$display("done: switches");
		cmd(4'h1, 4'h1, 1'b0, 32'h2904, 1'b0);
		cmd(4'h1, 4'h2, 1'b0, 32'hFFFFD6FC, 1'b0);
		cmd(4'h1, 4'h1, 1'b0, 32'h2905, 1'b1);
		cmd(4'h1, 4'h3, 1'b0, 32'h5, 1'b1);
		cmd(4'h0, 4'h1, 1'b0, 32'h0, 1'b1);
		rd(ADDR_AUXOUT, 32'hD6FC2904);
		rd(ADDR_STATUS, stat());
		cmd(4'h0, 4'h2, 1'b1, 32'h0, 1'b0);
		rd(ADDR_RESP, {{16{aux2[15]}}, aux2});
		cmd(4'h0, 4'h1, 1'b1, 32'h0, 1'b0);
		rd(ADDR_RESP, {{16{aux1[15]}}, aux1});
		clr();
		$display("done: aux");
		cmd(4'h7, 4'h5, 1'b0, 32'h0, 1'b1);
		cmd(4'h6, 4'h0, 1'b0, 32'h0, 1'b1);
		cmd(4'h6, 4'h9, 1'b0, 32'h0, 1'b0);
		cmd(4'h4, 4'h0, 1'b0, 32'h0, 1'b0);
		cmd(4'h1, 4'h1, 1'b0, 32'h1, 1'b0);
		cmd(4'h2, 4'h0, 1'b0, 32'h0, 1'b0);
		cmd(4'h7, 4'h9, 1'b0, 32'h0, 1'b0);
		port = 1'b0;
		rd(ADDR_AUXOUT, 32'hD6FC2904);
		rd(ADDR_STATUS, stat());
		clr();
		$display("done: setup");
		nq.push_back(33'h7FFF);
		cmd(4'h8, 4'h0, 1'b0, 32'h7FFF, 1'b0);
		nq.push_back(33'h8001);
		cmd(4'h8, 4'h0, 1'b0, 32'hFFFF8001, 1'b0);
		cmd(4'h8, 4'h0, 1'b0, 32'h8000, 1'b1);
		for (int c = 0; c < 128; c++)
		begin
			ok = c < 64 ? KEY_MAP_PLAIN[c] : KEY_MAP_SHIFT[c - 64];
			if (ok) kq.push_back({24'h0, 2'h3, c[6:0]});
			cmd(4'h9, 4'h0, 1'b0, c, !ok);
		end
		clr();
		$display("done: knob and keys");
		cmd(4'hF, 4'h0, 1'b0, 32'h0, 1'b1);
		cmd(4'h1, 4'h2, 1'b1, 32'h0, 1'b0);
		rd(ADDR_RESP, 32'hFFFFD6FC);
		rd(ADDR_STATUS, stat());
		clr();
		cmd(4'h3, 4'h0, 1'b0, 32'h0, 1'b0);
		ovr = 1'b0;
		pr(7'h5);
		kq.push_back({24'h0, 2'h2, KEY_LOCAL});
		pr(KEY_LOCAL);
		st = 2'h0;
		rd(ADDR_STATUS, stat());
		lockout_pin <= 1'b1;
		cmd(4'h5, 4'h0, 1'b0, 32'h1, 1'b0);
		pr(KEY_LOCAL);
		rd(ADDR_STATUS, stat());
		cmd(4'h3, 4'h0, 1'b0, 32'h1, 1'b0);
		ovr = 1'b1;
		kq.push_back({24'h0, 2'h2, 7'h5});
		pr(7'h5);
		cmd(4'hA, 4'h0, 1'b0, 32'h0, 1'b0);
		rd(ADDR_STATUS, stat());
		$display("done: panel");
		test_done();
	end
endmodule
bind remote_setup_command_decoder remote_setup_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.setup, .response_port, .panel_override_mode, .remote_led, .panel_enable, .key_event, .knob_event);
